// File: include/vaf_defs.vh
// constants for the virtual address former
`ifndef VAF_DEFS_VH
`define VAF_DEFS_VH

// apb register byte offsets
`define VAF_OFS_PROC    8'h00
`define VAF_OFS_STACK   8'h04
`define VAF_OFS_LINK    8'h08
`define VAF_OFS_AUX     8'h0c
`define VAF_OFS_CTRL    8'h10
`define VAF_OFS_LASTEA  8'h14
`define VAF_OFS_FAULTS  8'h18
`define VAF_OFS_INFO    8'h1c

// control register reset value (protection enabled)
`define VAF_CTRL_RST    1'b1

// virtual address fields, bit 1 is the msb [31]
`define VAF_F_BIT       31
`define VAF_RING_HI     30
`define VAF_RING_LO     29
`define VAF_E_BIT       28
`define VAF_SEG_HI      27
`define VAF_SEG_LO      16
`define VAF_OFF_HI      15
`define VAF_OFF_LO      0

// long memory-reference instruction fields
`define VAF_I_DEREF     31
`define VAF_I_PICKA     30
`define VAF_I_FN_HI     29
`define VAF_I_FN_LO     26
`define VAF_I_FMT_HI    25
`define VAF_I_FMT_LO    21
`define VAF_I_PICKB     20
`define VAF_I_FN2_HI    19
`define VAF_I_FN2_LO    18
`define VAF_I_BS_HI     17
`define VAF_I_BS_LO     16
`define VAF_FMT_LONG    5'h18

// base_sel encodings
`define VAF_BS_PROC     2'h0
`define VAF_BS_STACK    2'h1
`define VAF_BS_LINK     2'h2
`define VAF_BS_AUX      2'h3

// rings
`define VAF_RING_KERN   2'h0
`define VAF_RING_MID    2'h1
`define VAF_RING_USER   2'h3

// memory sizes: 512 mbyte virtual, 16 mbyte physical
`define VAF_VA_BYTE_W   29
`define VAF_PA_BYTE_W   24

`endif

// File: src/vaf_ring_chk.v
// ring permission check for one reference
`timescale 1ns/1ps
`default_nettype none
`include "vaf_defs.vh"

module vaf_ring_chk (
    // reference
    input  wire [1:0] ring,
    input  wire [2:0] acc,
    // segment rights {r,w,x} for this ring
    input  wire [2:0] perm,
    input  wire       prot_en,
    // verdict
    output wire       allow
);
    wire need_ok;

    // every needed right must be present for the segment
    assign need_ok = ((acc & ~perm) == 3'h0);
    // most privileged ring passes on every segment
    assign allow = !prot_en || (ring == `VAF_RING_KERN) || need_ok;
endmodule // vaf_ring_chk

`default_nettype wire

// File: src/vaf_top.v
// virtual address former with ring protection and apb registers
//
// Overview of operation
// - three rings 0, 1, 3; every reference checked
// - ring 0 may read, write, execute everything
// - ring 3 rights set per segment
// - bytes, halfwords, words; bit 1 is msb
// - offsets count halfwords from segment start
// - address: ring 2-3, segment 5-16, offset 17-32
// - bits 1 and 4 always zero
// - ring is highest of pc, base, indirect
// - segment from base, pc or indirect address
// - four 32-bit base registers
// - procedure_base offset is always zero
// - pc segment equals procedure_base segment
// - base offset plus const_offset, plus index
// - six offset forms
// - method chosen only from instruction fields
// - deref, picks, func_code, format bit layout
// - base_sel bits 15-16, const_offset 17-32
// - 16 mbyte physical, 512 mbyte virtual
// - base_sel 00 proc, 01 stack, 10 link, 11 aux
// - deref_flag set means indirect address
// - direct: base plus displacement plus index
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "vaf_defs.vh"

module vaf_top (
    // clock and reset
    input  wire        CLK,
    input  wire        RST_B,
    // apb slave
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [7:0]  PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output wire        PREADY,
    output wire        PSLVERR,
    // sequencer request
    input  wire        REQ_VLD,
    output wire        REQ_RDY,
    input  wire [31:0] INSTR,
    input  wire [31:0] PC,
    input  wire [15:0] IDX_X,
    input  wire [15:0] IDX_Y,
    input  wire [2:0]  ACC_RWX,
    // sequencer result
    output reg         DONE,
    output reg  [31:0] EA,
    output reg  [28:0] EA_BYTE,
    output reg         GRANT,
    output reg         PROT_FAULT,
    output reg         FMT_ERR,
    // indirect pointer fetch
    output wire        IND_REQ,
    output reg  [31:0] IND_ADDR,
    input  wire        IND_ACK,
    input  wire [31:0] IND_DATA,
    // translation unit rights lookup
    output wire        CHK_REQ,
    input  wire        MM_PERM_VLD,
    input  wire [2:0]  MM_PERM
);
    // states
    localparam [2:0] S_IDLE  = 3'b001;
    localparam [2:0] S_FETCH = 3'b010;
    localparam [2:0] S_CHECK = 3'b100;

    // sequencer state
    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    // base registers, control and fault count
    reg  [31:0] proc_q;
    reg  [31:0] stack_q;
    reg  [31:0] link_q;
    reg  [31:0] aux_q;
    reg         prot_en_q;
    reg  [15:0] faults_q;
    // request fields kept for the indirect and check steps
    reg  [1:0]  ring_q;
    reg  [15:0] idx_q;
    reg  [2:0]  acc_q;

    // bus decode
    wire        wr_en;
    wire        rd_en;
    wire        addr_ok;
    // instruction fields
    wire [1:0]  bs;
    wire        deref;
    wire        use_x;
    wire        use_y;
    wire        fmt_ok;
    wire [15:0] idx;
    // address datapath
    reg  [31:0] base;
    wire [1:0]  ring_pre;
    wire [11:0] seg_pre;
    wire [15:0] off_pre;
    wire [31:0] va_pre;
    wire [1:0]  ring_ind;
    wire [15:0] off_ind;
    wire        allow;

    // normalise a ring field: value 2 is not a ring, treat as 3
    // raising a stray 2 to 3 can only take rights away
    function [1:0] ring_norm;
        input [1:0] r;
        begin
            ring_norm = (r == 2'h2) ? `VAF_RING_USER : r;
        end
    endfunction

    // numerically highest of two rings
    function [1:0] ring_max;
        input [1:0] a;
        input [1:0] b;
        reg   [1:0] na;
        reg   [1:0] nb;
        begin
            na = ring_norm(a);
            nb = ring_norm(b);
            ring_max = (na > nb) ? na : nb;
        end
    endfunction

    // build a clean address: flag bits 1 and 4 forced to zero
    function [31:0] mk_va;
        input [1:0]  r;
        input [11:0] s;
        input [15:0] o;
        begin
            mk_va = {1'b0, r, 1'b0, s, o};
        end
    endfunction

    // scrub a base register write value
    function [31:0] scrub;
        input [31:0] v;
        input        is_proc;
        begin
            scrub = mk_va(v[`VAF_RING_HI:`VAF_RING_LO],
                          v[`VAF_SEG_HI:`VAF_SEG_LO],
                          is_proc ? 16'h0000 : v[`VAF_OFF_HI:`VAF_OFF_LO]);
        end
    endfunction

    // apb decode: zero wait states, unmapped answers with an error
    // writes to read-only or unmapped places change nothing
    assign wr_en   = PSEL && PENABLE && PWRITE;
    assign rd_en   = PSEL && !PWRITE;
    assign addr_ok = (PADDR[1:0] == 2'h0) && (PADDR <= `VAF_OFS_INFO);
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !addr_ok;

    // instruction field decode
    assign deref  = INSTR[`VAF_I_DEREF];
    assign use_x  = INSTR[`VAF_I_PICKA];
    assign use_y  = INSTR[`VAF_I_PICKB];
    assign fmt_ok = (INSTR[`VAF_I_FMT_HI:`VAF_I_FMT_LO] == `VAF_FMT_LONG);
    assign bs     = INSTR[`VAF_I_BS_HI:`VAF_I_BS_LO];
    // index chosen by the pick bits; both set adds both
    assign idx    = (use_x ? IDX_X : 16'h0000) + (use_y ? IDX_Y : 16'h0000);

    // base register selection
    always @* begin
        case (bs)
            `VAF_BS_PROC:  base = proc_q;
            `VAF_BS_STACK: base = stack_q;
            `VAF_BS_LINK:  base = link_q;
            `VAF_BS_AUX:   base = aux_q;
            default:       base = proc_q;
        endcase
    end

    // first-stage address: ring from pc and base, segment from base
    assign ring_pre = ring_max(PC[`VAF_RING_HI:`VAF_RING_LO],
                               base[`VAF_RING_HI:`VAF_RING_LO]);
    assign seg_pre  = base[`VAF_SEG_HI:`VAF_SEG_LO];
    // halfword offset: displacement + base offset (+ index if direct)
    assign off_pre  = INSTR[`VAF_OFF_HI:`VAF_OFF_LO]
                    + base[`VAF_OFF_HI:`VAF_OFF_LO]
                    + (deref ? 16'h0000 : idx);
    assign va_pre   = mk_va(ring_pre, seg_pre, off_pre);

    // indirect result: ring folds in the pointer, index added after
    // pointer flag bits are ignored: one level of indirection only
    assign ring_ind = ring_max(ring_q, IND_DATA[`VAF_RING_HI:`VAF_RING_LO]);
    assign off_ind  = IND_DATA[`VAF_OFF_HI:`VAF_OFF_LO] + idx_q;

    // handshakes
    // a request is taken only in idle; results pulse for one cycle
    assign REQ_RDY = (state_q == S_IDLE);
    assign IND_REQ = (state_q == S_FETCH);
    assign CHK_REQ = (state_q == S_CHECK);

    // permission verdict for the formed reference
    vaf_ring_chk u_chk (
        .ring    (EA[`VAF_RING_HI:`VAF_RING_LO]),
        .acc     (acc_q),
        .perm    (MM_PERM),
        .prot_en (prot_en_q),
        .allow   (allow)
    );

    // next state
    always @* begin
        // a refused format stays in idle and is answered at once
        state_d = state_q;
        case (state_q)
            S_IDLE: begin
                if (REQ_VLD && fmt_ok) begin
                    state_d = deref ? S_FETCH : S_CHECK;
                end
            end
            S_FETCH: begin
                if (IND_ACK) begin
                    state_d = S_CHECK;
                end
            end
            S_CHECK: begin
                if (MM_PERM_VLD) begin
                    state_d = S_IDLE;
                end
            end
            default: state_d = S_IDLE;
        endcase
    end

    // state, request capture and result outputs
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_q    <= S_IDLE;
            ring_q     <= 2'h0;
            idx_q      <= 16'h0000;
            acc_q      <= 3'h0;
            IND_ADDR   <= 32'h0000_0000;
            EA         <= 32'h0000_0000;
            EA_BYTE    <= 29'h0000_0000;
            DONE       <= 1'b0;
            GRANT      <= 1'b0;
            PROT_FAULT <= 1'b0;
            FMT_ERR    <= 1'b0;
        end else begin
            state_q    <= state_d;
            DONE       <= 1'b0;
            GRANT      <= 1'b0;
            PROT_FAULT <= 1'b0;
            FMT_ERR    <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (REQ_VLD && !fmt_ok) begin
                        DONE    <= 1'b1; // not a long reference, refused
                        FMT_ERR <= 1'b1;
                    end else if (REQ_VLD) begin
                        ring_q <= ring_pre;
                        idx_q  <= idx;
                        acc_q  <= ACC_RWX;
                        if (deref) begin
                            IND_ADDR <= va_pre;
                        end else begin
                            EA      <= va_pre;
                            // a halfword is two bytes: one shift left
                            EA_BYTE <= {seg_pre, off_pre, 1'b0};
                        end
                    end
                end
                S_FETCH: begin
                    if (IND_ACK) begin
                        // segment comes from the pointer itself
                        EA <= mk_va(ring_ind, IND_DATA[`VAF_SEG_HI:`VAF_SEG_LO], off_ind);
                        EA_BYTE <= {IND_DATA[`VAF_SEG_HI:`VAF_SEG_LO], off_ind, 1'b0};
                    end
                end
                S_CHECK: begin
                    if (MM_PERM_VLD) begin
                        DONE       <= 1'b1;
                        GRANT      <= allow;
                        PROT_FAULT <= !allow;
                    end
                end
                default: begin
                    DONE <= 1'b0;
                end
            endcase
        end
    end

    // base registers, control and fault counter
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            proc_q    <= 32'h0000_0000;
            stack_q   <= 32'h0000_0000;
            link_q    <= 32'h0000_0000;
            aux_q     <= 32'h0000_0000;
            prot_en_q <= `VAF_CTRL_RST;
            faults_q  <= 16'h0000;
        end else begin
            if (wr_en) begin
                case (PADDR)
                    `VAF_OFS_PROC:  proc_q  <= scrub(PWDATA, 1'b1);
                    `VAF_OFS_STACK: stack_q <= scrub(PWDATA, 1'b0);
                    `VAF_OFS_LINK:  link_q  <= scrub(PWDATA, 1'b0);
                    `VAF_OFS_AUX:   aux_q   <= scrub(PWDATA, 1'b0);
                    `VAF_OFS_CTRL:  prot_en_q <= PWDATA[0];
                    default:        prot_en_q <= prot_en_q;
                endcase
            end
            // the count wraps at 16 bits; software clears it in time
            // a fault in the clearing cycle still counts
            if (state_q == S_CHECK && MM_PERM_VLD && !allow) begin
                faults_q <= faults_q + 16'h0001;
            end else if (wr_en && PADDR == `VAF_OFS_FAULTS) begin
                faults_q <= 16'h0000;
            end
        end
    end

    // read data, registered in the setup cycle
    // so prdata stands still through the whole access cycle
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            PRDATA <= 32'h0000_0000;
        end else if (rd_en && !PENABLE) begin
            case (PADDR)
                `VAF_OFS_PROC:   PRDATA <= proc_q;
                `VAF_OFS_STACK:  PRDATA <= stack_q;
                `VAF_OFS_LINK:   PRDATA <= link_q;
                `VAF_OFS_AUX:    PRDATA <= aux_q;
                `VAF_OFS_CTRL:   PRDATA <= {31'h0000_0000, prot_en_q};
                `VAF_OFS_LASTEA: PRDATA <= EA;
                `VAF_OFS_FAULTS: PRDATA <= {16'h0000, faults_q};
                `VAF_OFS_INFO:   PRDATA <= {16'h0000, 3'h0, 5'd`VAF_VA_BYTE_W,
                                            3'h0, 5'd`VAF_PA_BYTE_W};
                default:         PRDATA <= 32'h0000_0000;
            endcase
        end
    end
endmodule // vaf_top

`default_nettype wire

// File: tb/vaf_top_sva.sv
// assertions on the ports of the virtual address former
`timescale 1ns/1ps
`default_nettype none
`include "vaf_defs.vh"
module vaf_top_chk (
    // clock and reset
    input wire logic        CLK,
    input wire logic        RST_B,
    // register bus
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic        PREADY,
    // sequencer side
    input wire logic        REQ_VLD,
    input wire logic        REQ_RDY,
    input wire logic [31:0] INSTR,
    input wire logic [2:0]  ACC_RWX,
    input wire logic        DONE,
    input wire logic [31:0] EA,
    input wire logic        GRANT,
    input wire logic        PROT_FAULT,
    input wire logic        FMT_ERR,
    // far side
    input wire logic        IND_REQ,
    input wire logic        CHK_REQ,
    input wire logic        MM_PERM_VLD,
    input wire logic [2:0]  MM_PERM
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // protection switch and needed rights, followed from the bus and the request
    logic       prot_m;
    logic [2:0] acc_m;
    // request taken, format legal, rights answer, missing rights
    wire       take = REQ_VLD && REQ_RDY;
    wire       fmt_ok = INSTR[25:21] == 5'h18;
    wire       pin = CHK_REQ && MM_PERM_VLD;
    wire [2:0] miss = acc_m & ~MM_PERM;
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            prot_m <= `VAF_CTRL_RST;
            acc_m <= 3'h0;
        end else begin
            if (PSEL && PENABLE && PREADY && PWRITE && PADDR == `VAF_OFS_CTRL) prot_m <= PWDATA[0];
            if (take) acc_m <= ACC_RWX;
        end
    end
    property p_zero; DONE && !FMT_ERR |-> !EA[31] && !EA[28]; endproperty
    a_zero: assert property (p_zero) else $error("flag bits set in ea");
    property p_ring; DONE && !FMT_ERR |-> EA[30:29] != 2'h2; endproperty
    a_ring: assert property (p_ring) else $error("ring two in ea");
    property p_one; DONE |-> $onehot({GRANT, PROT_FAULT, FMT_ERR}); endproperty
    a_one: assert property (p_one) else $error("verdict not one-hot");
    property p_kern; pin && EA[30:29] == 2'h0 |=> DONE && GRANT; endproperty
    a_kern: assert property (p_kern) else $error("ring zero refused");
    property p_user; pin && EA[30:29] == 2'h3 && prot_m |=> DONE && (GRANT == ($past(miss) == 3'h0)); endproperty
    a_user: assert property (p_user) else $error("ring three verdict wrong");
    property p_block; pin && prot_m && EA[30:29] != 2'h0 && miss != 3'h0 |=> PROT_FAULT && !GRANT; endproperty
    a_block: assert property (p_block) else $error("missing right granted");
    property p_off; pin && !prot_m |=> DONE && GRANT; endproperty
    a_off: assert property (p_off) else $error("unchecked reference refused");
    property p_ind; take && fmt_ok && INSTR[31] |=> IND_REQ && !CHK_REQ; endproperty
    a_ind: assert property (p_ind) else $error("no pointer fetch");
    property p_dir; take && fmt_ok && !INSTR[31] |=> CHK_REQ && !IND_REQ; endproperty
    a_dir: assert property (p_dir) else $error("direct reference fetched pointer");
    property p_fmt; take && !fmt_ok |=> DONE && FMT_ERR; endproperty
    a_fmt: assert property (p_fmt) else $error("bad format accepted");
    property p_chk; $rose(DONE) && !FMT_ERR |-> $past(CHK_REQ); endproperty
    a_chk: assert property (p_chk) else $error("result without rights check");
    property p_wait; CHK_REQ && !MM_PERM_VLD |=> CHK_REQ && !DONE; endproperty
    a_wait: assert property (p_wait) else $error("check abandoned");
    c_ind: cover property (take && INSTR[31]);
    c_fault: cover property (DONE && PROT_FAULT);
    c_fmt: cover property (DONE && FMT_ERR);
endmodule // vaf_top_chk
bind vaf_top vaf_top_chk u_vaf_top_chk (.CLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY,
    .REQ_VLD, .REQ_RDY, .INSTR, .ACC_RWX, .DONE, .EA, .GRANT,
    .PROT_FAULT, .FMT_ERR, .IND_REQ, .CHK_REQ, .MM_PERM_VLD, .MM_PERM);
`default_nettype wire

// File: tb/vaf_far_model.sv
// far side model: pointer memory and segment rights lookup
`timescale 1ns/1ps
`default_nettype none
module vaf_far_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // settings from the bench
    input  wire logic [3:0]  dly,
    input  wire logic [31:0] ptr,
    input  wire logic [2:0]  rights,
    // pointer fetch
    input  wire logic        ind_req,
    output var  logic        ind_ack,
    output var  logic [31:0] ind_data,
    // rights lookup
    input  wire logic        chk_req,
    output var  logic        perm_vld,
    output var  logic [2:0]  perm
);
    logic [3:0] cnt_q;
    // answer after dly cycles; data lines change every cycle outside the answer
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 4'h0;
            ind_ack <= 1'b0;
            perm_vld <= 1'b0;
            ind_data <= 32'h0;
            perm <= 3'h0;
        end else begin
            ind_ack <= 1'b0;
            perm_vld <= 1'b0;
            ind_data <= ~ind_data;
            perm <= ~perm;
            cnt_q <= 4'h0;
            if ((ind_req || chk_req) && !ind_ack && !perm_vld) begin
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q >= dly) begin
                    ind_ack <= ind_req;
                    perm_vld <= !ind_req;
                    ind_data <= ptr;
                    perm <= rights;
                end
            end
        end
    end
endmodule // vaf_far_model
`default_nettype wire

// File: tb/tb_vaf_top.sv
// self-checking bench for the virtual address former
`timescale 1ns/1ps
`default_nettype none
module tb_vaf_top;
    typedef struct {logic [31:0] ins, pc, ptr, ia, ea; logic [15:0] x, y; logic [2:0] acc, rt, vrd;} vaf_row_t;
    logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, req_vld = 0, err;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, instr = 0, pc = 0, ptr = 0, rd, ia_seen;
    logic [15:0] idx_x = 0, idx_y = 0;
    logic [2:0]  acc = 0, rights = 0;
    logic [3:0]  dly = 0;
    wire  [31:0] prdata, ea, ind_addr, ind_data;
    wire  [28:0] ea_byte;
    wire  [2:0]  mm_perm;
    wire         pready, pslverr, req_rdy, done, grant, prot_fault, fmt_err, ind_req, ind_ack, chk_req, mm_vld;
    int          miscompares = 0, checks = 0;
    vaf_row_t    rows [9];
    logic [31:0] bw [4] = '{32'ha005_1234, 32'h0010_0100, 32'h6020_0200, 32'h1030_0300};
    logic [31:0] bexp [4] = '{32'h2005_0000, 32'h0010_0100, 32'h6020_0200, 32'h0030_0300};
    vaf_top u_vaf_top (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .REQ_VLD(req_vld), .REQ_RDY(req_rdy), .INSTR(instr), .PC(pc), .IDX_X(idx_x), .IDX_Y(idx_y),
        .ACC_RWX(acc), .DONE(done), .EA(ea), .EA_BYTE(ea_byte), .GRANT(grant), .PROT_FAULT(prot_fault),
        .FMT_ERR(fmt_err), .IND_REQ(ind_req), .IND_ADDR(ind_addr), .IND_ACK(ind_ack), .IND_DATA(ind_data),
        .CHK_REQ(chk_req), .MM_PERM_VLD(mm_vld), .MM_PERM(mm_perm));
    vaf_far_model u_vaf_far_model (.clk(clk), .rst_b(rst_b), .dly(dly), .ptr(ptr), .rights(rights),
        .ind_req(ind_req), .ind_ack(ind_ack), .ind_data(ind_data), .chk_req(chk_req), .perm_vld(mm_vld),
        .perm(mm_perm));
    // clock, 8 ns period
    always #4 clk = ~clk;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk("pready", {31'h0, pready}, 32'h1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // one reference: request held until taken, then wait for the result
    task automatic run_ref(input vaf_row_t r);
        int n;
        {instr, pc, idx_x, idx_y, acc, ptr, rights} <= {r.ins, r.pc, r.x, r.y, r.acc, r.ptr, r.rt};
        req_vld <= 1'b1;
        do @(posedge clk); while (req_rdy !== 1'b1);
        req_vld <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (ind_req === 1'b1) ia_seen = ind_addr;
        end while (done !== 1'b1 && n < 60);
        chk("done", {31'h0, done}, 32'h1);
    endtask
    function automatic logic [31:0] mk(input logic d, a, b, input logic [1:0] bs, input logic [15:0] k);
        return {d, a, 4'h0, 5'h18, b, 2'h0, bs, k};
    endfunction
    // watchdog
    initial begin
        #40000;
        miscompares++;
        close_out();
    end
    initial begin
        rows[0] = '{32'h0, 0, 0, 0, 0, 0, 0, 3'h4, 3'h4, 3'b001};
        rows[1] = '{mk(0, 0, 0, 0, 16'h0010), 0, 0, 0, 32'h2005_0010, 0, 0, 3'h4, 3'h0, 3'b010};
        rows[2] = '{mk(0, 0, 0, 1, 16'h0005), 0, 0, 0, 32'h0010_0105, 0, 0, 3'h7, 3'h0, 3'b100};
        rows[3] = '{mk(0, 1, 1, 2, 16'h0001), 0, 0, 0, 32'h6020_0213, 16'h0010, 16'h0002, 3'h2, 3'h2, 3'b100};
        rows[4] = '{mk(0, 0, 0, 2, 16'h0000), 0, 0, 0, 32'h6020_0200, 0, 0, 3'h1, 3'h6, 3'b010};
        rows[5] = '{mk(0, 1, 0, 3, 16'h0010), 32'h6000_0000, 0, 0, 32'h6030_0311, 16'h0001, 0, 3'h4, 3'h4, 3'b100};
        rows[6] = '{mk(1, 0, 1, 1, 16'h0002), 0, 32'h2040_0008, 32'h0010_0102, 32'h2040_000c, 0, 16'h0004,
                    3'h4, 3'h4, 3'b100};
        rows[7] = '{mk(1, 0, 0, 0, 16'h0003), 0, 32'hf7ff_ffff, 32'h2005_0003, 32'h67ff_ffff, 0, 0, 3'h2, 3'h5,
                    3'b010};
        rows[8] = '{mk(0, 0, 0, 1, 16'h0000), 32'h4000_0000, 0, 0, 32'h6010_0100, 0, 0, 3'h4, 3'h4, 3'b100};
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        // base registers: flag bits and procedure offset forced to zero
        for (int i = 0; i < 4; i++) begin
            apb(8'(4 * i), 1'b1, bw[i]);
            apb(8'(4 * i), 1'b0, 32'h0);
            chk("base reg", rd, bexp[i]);
        end
        foreach (rows[i]) begin
            dly <= 4'(i);
            run_ref(rows[i]);
            chk("verdict", {29'h0, grant, prot_fault, fmt_err}, {29'h0, rows[i].vrd});
            if (!rows[i].vrd[0]) begin
                chk("ea", ea, rows[i].ea);
                chk("ea byte", {3'h0, ea_byte}, {3'h0, rows[i].ea[27:0], 1'b0});
            end
            if (rows[i].ins[31]) chk("ptr addr", ia_seen, rows[i].ia);
        end
        // fault counter, last address, unmapped and unaligned places
        apb(8'h18, 1'b0, 32'h0);
        chk("fault count", rd, 32'h3);
        apb(8'h18, 1'b1, 32'h0);
        apb(8'h18, 1'b0, 32'h0);
        chk("fault clear", rd, 32'h0);
        apb(8'h14, 1'b0, 32'h0);
        chk("last ea", rd, 32'h6010_0100);
        apb(8'h20, 1'b0, 32'h0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        apb(8'h06, 1'b1, 32'h0fff_ffff);
        apb(8'h04, 1'b0, 32'h0);
        chk("unaligned write", rd, 32'h0010_0100);
        // protection switched off: a missing right is granted and not counted
        apb(8'h10, 1'b1, 32'h0);
        run_ref(rows[4]);
        chk("prot off", {29'h0, grant, prot_fault, fmt_err}, 32'h4);
        apb(8'h18, 1'b0, 32'h0);
        chk("no count when off", rd, 32'h0);
        // second reset in mid-run, then reset values
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            apb(8'(4 * i), 1'b0, 32'h0);
            chk("reset value", rd, i == 4 ? 32'h1 : i == 7 ? 32'h0000_1d18 : 32'h0);
        end
        close_out();
    end
endmodule // tb_vaf_top
`default_nettype wire
